// >>> hdl/imd_datapath.sv
// Integer datapath: register file, bypass, single-cycle ALU, mul/div unit
`timescale 1ns/1ns
`include "imd_defines.svh"
// Operation
// - Thirty-two 32-bit registers, two reads, one write
// - Fresh results bypass to close consumers
// - Logic, shift, add, subtract in one cycle
// - Leading zero and leading one counter
// - Separate 32-bit adder forms data addresses
// - Mul/div unit advances regardless of pipeline stalls
// - 32x16 multiplier, result pair, divide machine
// - Second operand size picks one or two passes
// - Short multiply each cycle, long every other
// - Divider yields one quotient bit per clock
// - Dividend sign extension skips 23/15/7 iterations
// - Mul/div instruction during divide stalls issue
// - Pair multiplies: 1/1 short, 2/2 long
// - Register multiply: 2/1 short, 3/2 long
// - Divide timing 11/11, 18/18, 25/25, 32/32
// - Results in pair; move ops copy them out
// - Register multiply writes low product to register
// - Accumulate adds product to result pair
// - Deduct subtracts product from result pair
module imd_datapath (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // Issue
   input wire logic ISSUE_VALID,
   input wire imd_pkg::imd_op_t OPCODE,
   input wire logic [4:0] SRC_A_ADDR,
   input wire logic [4:0] SRC_B_ADDR,
   input wire logic [4:0] DEST_ADDR,
   input wire logic [15:0] IMM,
   // Register writeback
   output logic RESULT_VALID,
   output logic [4:0] RESULT_ADDR,
   output logic [31:0] RESULT_DATA,
   // Data address
   output logic DATA_ADDR_VALID,
   output logic [31:0] DATA_ADDR,
   // Result pair and interlocks
   output logic [31:0] UPPER_WORD,
   output logic [31:0] LOWER_WORD,
   output logic MUL_DIV_STALL,
   output logic WRITE_STALL
);
   import imd_pkg::*;

   function automatic logic [31:0] pick(input logic [4:0] a, input logic hit_v,
      input logic [4:0] hit_a, input logic [31:0] hit_d, input logic [31:0] stored);
      pick = (hit_v && hit_a == a) ? hit_d : stored;
   endfunction

   function automatic logic [31:0] lead_zeros(input logic [31:0] v);
      lead_zeros = 32'h0000_0020;
      for (int i = 0; i < 32; i++) begin
         if (v[i]) begin
            lead_zeros = 32'(31 - i);
         end
      end
   endfunction

   // Booth recoding of the 33x17 array is left to the multiplier generator
   function automatic logic [63:0] mul_pass(input logic [32:0] a, input logic [16:0] b);
      logic signed [49:0] p;
      p = $signed(a) * $signed(b);
      mul_pass = 64'(p);
   endfunction

   function automatic logic fits(input logic [31:0] v, input int n, input logic sgn);
      logic [31:0] top;
      top = sgn ? 32'($signed(v) >>> (n - 1)) : (v >> n);
      fits = (top == '0) || (sgn && top == '1);
   endfunction

   function automatic logic [63:0] merge(input imd_op_t o, input logic [63:0] acc,
      input logic [63:0] p);
      case (o)
         IMD_OP_MUL_ACC, IMD_OP_MUL_ACC_U: merge = acc + p;
         IMD_OP_MUL_DEDUCT, IMD_OP_MUL_DEDUCT_U: merge = acc - p;
         default: merge = p;
      endcase
   endfunction

   // Restoring step: remainder in the upper half, shifting quotient below
   function automatic logic [63:0] div_step(input logic [31:0] r, input logic [31:0] q,
      input logic [31:0] d);
      logic [32:0] t;
      t = {r, q[31]} - {1'b0, d};
      div_step = t[32] ? {r[30:0], q[31], q[30:0], 1'b0} : {t[31:0], q[30:0], 1'b1};
   endfunction

   imd_state_t state;
   imd_state_t next_state;
   logic [31:0] gen_reg [0:31];
   logic md_valid;
   logic [4:0] md_addr;
   logic [31:0] md_data;
   imd_op_t p_op;
   logic p_greg;
   logic [4:0] p_dest;
   logic [32:0] p_a;
   logic [16:0] p_b_high;
   logic [63:0] p_one;
   logic [31:0] rem;
   logic [31:0] quo;
   logic [31:0] divisor;
   logic [5:0] iter;
   logic [5:0] cnt;
   logic q_neg;
   logic r_neg;
   logic [31:0] alu_res;

   // Operand read with bypass from the writeback stage
   wire imd_op_t op = OPCODE;
   wire [31:0] src_a = pick(SRC_A_ADDR, RESULT_VALID, RESULT_ADDR, RESULT_DATA,
      gen_reg[SRC_A_ADDR]);
   wire [31:0] src_b = pick(SRC_B_ADDR, RESULT_VALID, RESULT_ADDR, RESULT_DATA,
      gen_reg[SRC_B_ADDR]);

   // Decode
   wire is_pair = op inside {IMD_OP_MUL_PAIR, IMD_OP_MUL_PAIR_U, IMD_OP_MUL_ACC,
      IMD_OP_MUL_ACC_U, IMD_OP_MUL_DEDUCT, IMD_OP_MUL_DEDUCT_U};
   wire is_greg_mul = op == IMD_OP_MUL_GREG;
   wire is_div = op inside {IMD_OP_DIVIDE, IMD_OP_DIVIDE_U};
   wire is_move = op inside {IMD_OP_MOVE_UPPER, IMD_OP_MOVE_LOWER};
   wire is_mul = is_pair || is_greg_mul;
   wire is_md = is_mul || is_div || is_move;
   wire is_addr = op == IMD_OP_ADDR_CALC;
   wire direct_wr = !is_addr && (!is_md || is_move);
   wire sgn = op inside {IMD_OP_MUL_PAIR, IMD_OP_MUL_ACC, IMD_OP_MUL_DEDUCT,
      IMD_OP_MUL_GREG, IMD_OP_DIVIDE};
   // Any mul/div op waits out a busy unit; direct writers yield the write port
   wire taken = ISSUE_VALID && !(is_md && MUL_DIV_STALL)
      && !(direct_wr && WRITE_STALL);

   // Multiplier passes
   wire b_short = fits(src_b, `IMD_MUL_SHORT_BITS, sgn);
   wire [32:0] a_ext = {sgn & src_a[31], src_a};
   wire [16:0] b_low = {sgn & b_short & src_b[15], src_b[15:0]};
   wire [16:0] b_high = {sgn & src_b[31], src_b[31:16]};
   wire [63:0] pass_one = mul_pass(a_ext, b_low);
   wire [63:0] upper_part = mul_pass(p_a, p_b_high);
   wire [63:0] full_prod = p_one + {upper_part[47:0], 16'h0000};
   wire [63:0] pair_now = {UPPER_WORD, LOWER_WORD};
   wire short_pair = taken && is_pair && b_short;
   wire long_mul = taken && is_mul && !b_short;
   wire in_pass2 = state == IMD_ST_PASS2;

   // Divider set-up
   wire [31:0] mag_a = (sgn && src_a[31]) ? 32'(-src_a) : src_a;
   wire [31:0] mag_b = (sgn && src_b[31]) ? 32'(-src_b) : src_b;
   wire fit8 = fits(src_a, 8, sgn);
   wire fit16 = fits(src_a, 16, sgn);
   wire fit24 = fits(src_a, 24, sgn);
   wire [5:0] skip = fit8 ? `IMD_DIV_SKIP_8 : fit16 ? `IMD_DIV_SKIP_16
      : fit24 ? `IMD_DIV_SKIP_24 : `IMD_DIV_SKIP_32;
   wire [5:0] div_rpt = fit8 ? `IMD_DIV_RPT_8 : fit16 ? `IMD_DIV_RPT_16
      : fit24 ? `IMD_DIV_RPT_24 : `IMD_DIV_RPT_32;
   wire [63:0] first_step = div_step(32'h0000_0000, mag_a << skip, mag_b);
   wire div_start = taken && is_div;
   wire in_div = state == IMD_ST_DIVIDE;
   wire div_live = in_div && iter != 6'h00;
   wire [63:0] step_now = div_step(rem, quo, divisor);
   wire [31:0] next_rem = div_live ? step_now[63:32] : rem;
   wire [31:0] next_quo = div_live ? step_now[31:0] : quo;
   wire div_done = in_div && cnt == 6'h01;

   // Result pair update
   wire pair_load = short_pair || (in_pass2 && !p_greg) || div_done;
   wire [63:0] next_pair = div_done
      ? {r_neg ? 32'(-next_rem) : next_rem, q_neg ? 32'(-next_quo) : next_quo}
      : in_pass2 ? merge(p_op, pair_now, full_prod)
      : merge(op, pair_now, pass_one);

   // Writeback stages
   wire next_md_valid = (in_pass2 && p_greg) || (taken && is_greg_mul && b_short);
   wire [4:0] next_md_addr = in_pass2 ? p_dest : DEST_ADDR;
   wire [31:0] next_md_data = in_pass2 ? full_prod[31:0] : pass_one[31:0];
   wire next_wb_valid = md_valid || (taken && direct_wr);
   wire [4:0] next_wb_addr = md_valid ? md_addr : DEST_ADDR;
   wire [31:0] next_wb_data = md_valid ? md_data : alu_res;

   // Single-cycle ALU
   always_comb begin
      case (op)
         IMD_OP_ADD: alu_res = src_a + src_b;
         IMD_OP_SUB: alu_res = src_a - src_b;
         IMD_OP_AND: alu_res = src_a & src_b;
         IMD_OP_OR: alu_res = src_a | src_b;
         IMD_OP_XOR: alu_res = src_a ^ src_b;
         IMD_OP_NOR: alu_res = ~(src_a | src_b);
         IMD_OP_SHL: alu_res = src_a << src_b[4:0];
         IMD_OP_SHR: alu_res = src_a >> src_b[4:0];
         IMD_OP_SHRA: alu_res = 32'($signed(src_a) >>> src_b[4:0]);
         IMD_OP_LEAD_ZEROS: alu_res = lead_zeros(src_a);
         IMD_OP_LEAD_ONES: alu_res = lead_zeros(~src_a);
         IMD_OP_MOVE_UPPER: alu_res = UPPER_WORD;
         IMD_OP_MOVE_LOWER: alu_res = LOWER_WORD;
         default: alu_res = 32'h0000_0000;
      endcase
   end

   // No hold input: the unit keeps stepping whatever the pipeline does
   always_comb begin
      case (state)
         IMD_ST_IDLE: begin
            if (long_mul) begin
               next_state = IMD_ST_PASS2;
            end else if (div_start) begin
               next_state = IMD_ST_DIVIDE;
            end else begin
               next_state = IMD_ST_IDLE;
            end
         end
         IMD_ST_PASS2: next_state = IMD_ST_IDLE;
         IMD_ST_DIVIDE: next_state = div_done ? IMD_ST_IDLE : IMD_ST_DIVIDE;
         default: next_state = IMD_ST_IDLE;
      endcase
   end

   // Register file; no reset on the array
   always_ff @(posedge CLK) begin
      if (RESULT_VALID) begin
         gen_reg[RESULT_ADDR] <= RESULT_DATA;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         state <= IMD_ST_IDLE;
         MUL_DIV_STALL <= 1'b0;
         WRITE_STALL <= 1'b0;
      end else begin
         state <= next_state;
         MUL_DIV_STALL <= next_state != IMD_ST_IDLE;
         WRITE_STALL <= next_md_valid;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         md_valid <= 1'b0;
         md_addr <= 5'h00;
         md_data <= 32'h0000_0000;
         RESULT_VALID <= 1'b0;
         RESULT_ADDR <= 5'h00;
         RESULT_DATA <= 32'h0000_0000;
      end else begin
         // Extra stage gives the register multiply its longer latency
         md_valid <= next_md_valid;
         md_addr <= next_md_addr;
         md_data <= next_md_data;
         RESULT_VALID <= next_wb_valid;
         RESULT_ADDR <= next_wb_addr;
         RESULT_DATA <= next_wb_data;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         DATA_ADDR_VALID <= 1'b0;
         DATA_ADDR <= 32'h0000_0000;
      end else begin
         DATA_ADDR_VALID <= taken && is_addr;
         if (taken && is_addr) begin
            DATA_ADDR <= src_a + {{16{IMM[15]}}, IMM};
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         UPPER_WORD <= 32'h0000_0000;
         LOWER_WORD <= 32'h0000_0000;
      end else if (pair_load) begin
         UPPER_WORD <= next_pair[63:32];
         LOWER_WORD <= next_pair[31:0];
      end
   end

   // First pass of a long multiply parks here for the second
   always_ff @(posedge CLK) begin
      if (RESET) begin
         p_op <= IMD_OP_ADD;
         p_greg <= 1'b0;
         p_dest <= 5'h00;
         p_a <= 33'h0_0000_0000;
         p_b_high <= 17'h0_0000;
         p_one <= 64'h0000_0000_0000_0000;
      end else if (long_mul) begin
         p_op <= op;
         p_greg <= is_greg_mul;
         p_dest <= DEST_ADDR;
         p_a <= a_ext;
         p_b_high <= b_high;
         p_one <= pass_one;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         rem <= 32'h0000_0000;
         quo <= 32'h0000_0000;
         divisor <= 32'h0000_0000;
         iter <= 6'h00;
         cnt <= 6'h00;
         q_neg <= 1'b0;
         r_neg <= 1'b0;
      end else if (div_start) begin
         rem <= first_step[63:32];
         quo <= first_step[31:0];
         divisor <= mag_b;
         iter <= `IMD_DIV_STEPS - skip;
         cnt <= div_rpt - 6'h01;
         q_neg <= sgn && (src_a[31] ^ src_b[31]);
         r_neg <= sgn && src_a[31];
      end else if (in_div) begin
         rem <= next_rem;
         quo <= next_quo;
         iter <= div_live ? iter - 6'h01 : iter;
         cnt <= cnt - 6'h01;
      end
   end

   // Checks
   wire div_full = div_start && !fit24;
   wire div_byte = div_start && fit8;

   alu_add_a: assert property (@(posedge CLK) disable iff (RESET)
      taken && op == IMD_OP_ADD |=> RESULT_VALID && RESULT_DATA == $past(src_a) + $past(src_b))
      else $error("add result wrong");
   bypass_fwd_a: assert property (@(posedge CLK) disable iff (RESET)
      taken && op == IMD_OP_ADD && RESULT_VALID && SRC_A_ADDR == RESULT_ADDR
      && SRC_B_ADDR == RESULT_ADDR |=> RESULT_DATA == $past(RESULT_DATA) + $past(RESULT_DATA))
      else $error("bypass missed");
   lead_zero_a: assert property (@(posedge CLK) disable iff (RESET)
      taken && op == IMD_OP_LEAD_ZEROS && src_a == 32'h0000_0000
      |=> RESULT_DATA == 32'h0000_0020)
      else $error("zero count wrong");
   addr_adder_a: assert property (@(posedge CLK) disable iff (RESET)
      taken && is_addr |=> DATA_ADDR_VALID && DATA_ADDR == $past(src_a) + 32'($signed($past(IMM))))
      else $error("data address wrong");
   long_mul_a: assert property (@(posedge CLK) disable iff (RESET)
      long_mul |=> MUL_DIV_STALL ##1 !MUL_DIV_STALL)
      else $error("long multiply interlock wrong");
   short_acc_a: assert property (@(posedge CLK) disable iff (RESET)
      short_pair && op == IMD_OP_MUL_ACC_U |=> !MUL_DIV_STALL
      && pair_now == $past(pair_now) + 64'($past(src_a)) * 64'($past(src_b)))
      else $error("accumulate wrong");
   greg_mul_a: assert property (@(posedge CLK) disable iff (RESET)
      taken && is_greg_mul && b_short |=> WRITE_STALL && RESULT_VALID == $past(WRITE_STALL)
      ##1 RESULT_VALID && RESULT_ADDR == $past(DEST_ADDR, 2)
      && RESULT_DATA == 32'($past(src_a, 2) * $past(src_b, 2)))
      else $error("register multiply timing wrong");
   div_full_a: assert property (@(posedge CLK) disable iff (RESET)
      div_full |=> MUL_DIV_STALL ##30 MUL_DIV_STALL ##1 !MUL_DIV_STALL)
      else $error("full divide timing wrong");
   div_byte_a: assert property (@(posedge CLK) disable iff (RESET)
      div_byte |=> MUL_DIV_STALL ##9 MUL_DIV_STALL ##1 !MUL_DIV_STALL)
      else $error("short divide timing wrong");
endmodule

// >>> hdl/imd_defines.svh
// Cycle counts and the short operand width for the integer mul/div datapath
`ifndef IMD_DEFINES_SVH
`define IMD_DEFINES_SVH
`define IMD_DIV_SKIP_8 6'h17
`define IMD_DIV_SKIP_16 6'h0F
`define IMD_DIV_SKIP_24 6'h07
`define IMD_DIV_SKIP_32 6'h00
`define IMD_DIV_RPT_8 6'h0B
`define IMD_DIV_RPT_16 6'h12
`define IMD_DIV_RPT_24 6'h19
`define IMD_DIV_RPT_32 6'h20
`define IMD_DIV_STEPS 6'h1F
`define IMD_MUL_SHORT_BITS 16
`endif

// >>> hdl/imd_pkg.sv
// Types for the integer mul/div datapath
package imd_pkg;
   typedef enum logic [4:0] {
      IMD_OP_ADD, IMD_OP_SUB, IMD_OP_AND, IMD_OP_OR, IMD_OP_XOR, IMD_OP_NOR,
      IMD_OP_SHL, IMD_OP_SHR, IMD_OP_SHRA, IMD_OP_LEAD_ZEROS, IMD_OP_LEAD_ONES,
      IMD_OP_ADDR_CALC, IMD_OP_MUL_PAIR, IMD_OP_MUL_PAIR_U, IMD_OP_MUL_ACC,
      IMD_OP_MUL_ACC_U, IMD_OP_MUL_DEDUCT, IMD_OP_MUL_DEDUCT_U, IMD_OP_MUL_GREG,
      IMD_OP_DIVIDE, IMD_OP_DIVIDE_U, IMD_OP_MOVE_UPPER, IMD_OP_MOVE_LOWER
   } imd_op_t;
   typedef enum logic [2:0] {
      IMD_ST_IDLE = 3'b001,
      IMD_ST_PASS2 = 3'b010,
      IMD_ST_DIVIDE = 3'b100
   } imd_state_t;
endpackage

// >>> testbench/imd_issue_model.sv
// Issue-side model: holds one instruction until the datapath takes it
`timescale 1ns/1ns
module imd_issue_model (
   // Clock
   input wire logic CLK,
   // Interlocks
   input wire logic MUL_DIV_STALL,
   input wire logic WRITE_STALL,
   // Issue
   output logic ISSUE_VALID,
   output imd_pkg::imd_op_t OPCODE,
   output logic [4:0] SRC_A_ADDR,
   output logic [4:0] SRC_B_ADDR,
   output logic [4:0] DEST_ADDR,
   output logic [15:0] IMM
);
   import imd_pkg::*;
   initial begin
      ISSUE_VALID = 1'b0;
      OPCODE = IMD_OP_ADD;
      {SRC_A_ADDR, SRC_B_ADDR, DEST_ADDR, IMM} = '0;
   end
   // No accept output, so refusal is judged here from the stalls
   task automatic issue(input imd_op_t op, input logic [4:0] a, b, d, input logic [15:0] imm);
      logic md;
      logic wr;
      logic refused;
      int n;
      md = op >= IMD_OP_MUL_PAIR;
      wr = op <= IMD_OP_LEAD_ONES || op >= IMD_OP_MOVE_UPPER;
      refused = 1'b1;
      n = 0;
      @(negedge CLK);
      ISSUE_VALID = 1'b1;
      OPCODE = op;
      SRC_A_ADDR = a;
      SRC_B_ADDR = b;
      DEST_ADDR = d;
      IMM = imm;
      while (refused && n < 64) begin
         refused = (md && MUL_DIV_STALL) || (wr && WRITE_STALL);
         @(posedge CLK);
         if (refused) @(negedge CLK);
         n++;
      end
   endtask
   task automatic rest();
      @(negedge CLK);
      ISSUE_VALID = 1'b0;
      SRC_A_ADDR = ~SRC_A_ADDR;
   endtask
endmodule

// >>> testbench/integer_muldiv_datapath_bench.sv
// Self-checking bench for the integer mul/div datapath
`timescale 1ns/1ns
module integer_muldiv_datapath_bench;
   import imd_pkg::*;
   logic CLK;
   logic RESET;
   logic ISSUE_VALID;
   imd_op_t OPCODE;
   logic [4:0] SRC_A_ADDR;
   logic [4:0] SRC_B_ADDR;
   logic [4:0] DEST_ADDR;
   logic [15:0] IMM;
   logic RESULT_VALID;
   logic [4:0] RESULT_ADDR;
   logic [31:0] RESULT_DATA;
   logic DATA_ADDR_VALID;
   logic [31:0] DATA_ADDR;
   logic [31:0] UPPER_WORD;
   logic [31:0] LOWER_WORD;
   logic MUL_DIV_STALL;
   logic WRITE_STALL;
   int n_errors = 0;
   int comparisons = 0;
   imd_datapath imd_datapath_i (.CLK(CLK), .RESET(RESET), .ISSUE_VALID(ISSUE_VALID),
      .OPCODE(OPCODE), .SRC_A_ADDR(SRC_A_ADDR), .SRC_B_ADDR(SRC_B_ADDR),
      .DEST_ADDR(DEST_ADDR), .IMM(IMM), .RESULT_VALID(RESULT_VALID),
      .RESULT_ADDR(RESULT_ADDR), .RESULT_DATA(RESULT_DATA), .DATA_ADDR_VALID(DATA_ADDR_VALID),
      .DATA_ADDR(DATA_ADDR), .UPPER_WORD(UPPER_WORD), .LOWER_WORD(LOWER_WORD),
      .MUL_DIV_STALL(MUL_DIV_STALL), .WRITE_STALL(WRITE_STALL));
   imd_issue_model imd_issue_model_i (.CLK(CLK), .MUL_DIV_STALL(MUL_DIV_STALL),
      .WRITE_STALL(WRITE_STALL), .ISSUE_VALID(ISSUE_VALID), .OPCODE(OPCODE),
      .SRC_A_ADDR(SRC_A_ADDR), .SRC_B_ADDR(SRC_B_ADDR), .DEST_ADDR(DEST_ADDR), .IMM(IMM));
   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Sample just after an edge, once registered outputs have settled
   task automatic after(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic go(input imd_op_t op, input int a, b, d, input logic [15:0] imm);
      imd_issue_model_i.issue(op, 5'(a), 5'(b), 5'(d), imm);
   endtask
   task automatic alu(input imd_op_t op, input int a, b, d, input logic [31:0] exp);
      go(op, a, b, d, 16'h0000);
      #1;
      chk("result valid", 32'h1, 32'(RESULT_VALID));
      chk("result addr", 32'(d), 32'(RESULT_ADDR));
      chk("result data", exp, RESULT_DATA);
   endtask
   task automatic pair_chk(input logic [31:0] up, input logic [31:0] low);
      chk("upper word", up, UPPER_WORD);
      chk("lower word", low, LOWER_WORD);
   endtask
   task automatic pair(input imd_op_t op, input int a, b, lat, input logic [31:0] up, low);
      go(op, a, b, 0, 16'h0000);
      imd_issue_model_i.rest();
      after(0);
      chk("long stall", 32'(lat == 2), 32'(MUL_DIV_STALL));
      if (lat == 2) after(1);
      pair_chk(up, low);
   endtask
   task automatic b2b(input int b, lat, input logic [31:0] up, low);
      time t;
      go(IMD_OP_MUL_PAIR, 8, b, 0, 16'h0000);
      t = $time;
      go(IMD_OP_MUL_PAIR, 8, b, 0, 16'h0000);
      chk("issue spacing", 32'(lat * 8), 32'($time - t));
      imd_issue_model_i.rest();
      after(lat - 1);
      pair_chk(up, low);
   endtask
   task automatic greg(input int b, lat, input logic [31:0] exp);
      go(IMD_OP_MUL_GREG, 8, b, 21, 16'h0000);
      imd_issue_model_i.rest();
      after(lat - 2);
      chk("write stall", 32'h1, 32'(WRITE_STALL));
      chk("early result", 32'h0, 32'(RESULT_VALID));
      after(1);
      chk("result valid", 32'h1, 32'(RESULT_VALID));
      chk("result data", exp, RESULT_DATA);
      chk("result addr", 32'h15, 32'(RESULT_ADDR));
   endtask
   task automatic div(input imd_op_t op, input int a, rpt, input logic [31:0] q, r);
      int n;
      go(op, a, 5, 0, 16'h0000);
      imd_issue_model_i.rest();
      after(0);
      n = 0;
      while (MUL_DIV_STALL === 1'b1 && n < 40) begin
         n++;
         after(1);
      end
      chk("divide stall cycles", 32'(rpt - 1), 32'(n));
      pair_chk(r, q);
   endtask
   task automatic t_reset();
      repeat (6) @(posedge CLK);
      @(negedge CLK);
      RESET = 1'b0;
      chk("reset outputs", 32'h0, {29'h0, RESULT_VALID, MUL_DIV_STALL, WRITE_STALL});
      chk("reset upper", 32'h0, UPPER_WORD);
      $display("test reset done");
   endtask
   // Constants are built from the cleared pair, each one up to register 7 right behind its producer
   task automatic t_alu();
      alu(IMD_OP_MOVE_UPPER, 0, 0, 0, 32'h0);
      alu(IMD_OP_NOR, 0, 0, 1, 32'hFFFFFFFF);
      alu(IMD_OP_SUB, 0, 1, 2, 32'h1);
      alu(IMD_OP_ADD, 2, 2, 4, 32'h2);
      alu(IMD_OP_ADD, 4, 4, 5, 32'h4);
      alu(IMD_OP_ADD, 5, 5, 6, 32'h8);
      alu(IMD_OP_ADD, 6, 6, 7, 32'h10);
      alu(IMD_OP_ADD, 7, 6, 11, 32'h18);
      alu(IMD_OP_SHL, 2, 7, 8, 32'h10000);
      alu(IMD_OP_SHL, 2, 6, 9, 32'h100);
      alu(IMD_OP_SHL, 2, 11, 10, 32'h1000000);
      alu(IMD_OP_SHR, 10, 6, 17, 32'h10000);
      alu(IMD_OP_SHRA, 1, 7, 16, 32'hFFFFFFFF);
      alu(IMD_OP_OR, 8, 9, 18, 32'h10100);
      alu(IMD_OP_AND, 18, 9, 19, 32'h100);
      alu(IMD_OP_XOR, 18, 9, 31, 32'h10000);
      alu(IMD_OP_LEAD_ZEROS, 0, 0, 12, 32'h20);
      alu(IMD_OP_LEAD_ONES, 1, 0, 13, 32'h20);
      alu(IMD_OP_LEAD_ZEROS, 10, 0, 14, 32'h7);
      alu(IMD_OP_LEAD_ONES, 2, 0, 15, 32'h0);
      alu(IMD_OP_ADD, 31, 12, 30, 32'h10020);
      go(IMD_OP_ADDR_CALC, 8, 0, 0, 16'hFFFF);
      imd_issue_model_i.rest();
      after(0);
      chk("addr valid", 32'h1, 32'(DATA_ADDR_VALID));
      chk("data addr", 32'hFFFF, DATA_ADDR);
      chk("no register write", 32'h0, 32'(RESULT_VALID));
      after(1);
      chk("addr valid", 32'h0, 32'(DATA_ADDR_VALID));
      $display("test alu done");
   endtask
   task automatic t_mul();
      b2b(7, 1, 32'h0, 32'h100000);
      b2b(8, 2, 32'h1, 32'h0);
      pair(IMD_OP_MUL_PAIR, 1, 7, 1, 32'hFFFFFFFF, 32'hFFFFFFF0);
      pair(IMD_OP_MUL_PAIR_U, 1, 7, 1, 32'hF, 32'hFFFFFFF0);
      pair(IMD_OP_MUL_ACC, 2, 7, 1, 32'h10, 32'h0);
      pair(IMD_OP_MUL_DEDUCT, 4, 5, 1, 32'hF, 32'hFFFFFFF8);
      pair(IMD_OP_MUL_ACC_U, 8, 8, 2, 32'h10, 32'hFFFFFFF8);
      pair(IMD_OP_MUL_DEDUCT_U, 2, 2, 1, 32'h10, 32'hFFFFFFF7);
      greg(7, 2, 32'h100000);
      greg(8, 3, 32'h0);
      pair_chk(32'h10, 32'hFFFFFFF7);
      $display("test multiply done");
   endtask
   task automatic t_div();
      time t;
      div(IMD_OP_DIVIDE, 7, 11, 32'h4, 32'h0);
      div(IMD_OP_DIVIDE, 9, 18, 32'h40, 32'h0);
      div(IMD_OP_DIVIDE, 8, 25, 32'h4000, 32'h0);
      div(IMD_OP_DIVIDE, 10, 32, 32'h400000, 32'h0);
      div(IMD_OP_DIVIDE, 1, 11, 32'h0, 32'hFFFFFFFF);
      div(IMD_OP_DIVIDE_U, 1, 32, 32'h3FFFFFFF, 32'h3);
      go(IMD_OP_DIVIDE, 7, 5, 0, 16'h0000);
      t = $time;
      alu(IMD_OP_ADD, 7, 7, 22, 32'h20);
      chk("divide busy", 32'h1, 32'(MUL_DIV_STALL));
      alu(IMD_OP_MOVE_LOWER, 0, 0, 23, 32'h4);
      // Eleven cycles to the take, plus the sampling step
      chk("held move", 32'h59, 32'($time - t));
      imd_issue_model_i.rest();
      $display("test divide done");
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge CLK);
      n_errors++;
      $display("watchdog expired");
      complete_run();
   end
   initial begin
      RESET = 1'b1;
      t_reset();
      t_alu();
      t_mul();
      t_div();
      complete_run();
   end
endmodule
